// *** core/lsbc_pkg.sv ***
// Constants and types for the locked and special bus cycle sequencer
package lsbc_pkg;
    // Sequencer states, one-hot
    typedef enum logic [9:0] {
        S_IDLE  = 10'h001,
        S_FLUSH = 10'h002,
        S_ADDR  = 10'h004,
        S_DATA  = 10'h008,
        S_BACKOFF_N  = 10'h010,
        S_WB    = 10'h020,
        S_GAP   = 10'h040,
        S_EXT_WRITE_BUFFER_EMPTY_N  = 10'h080,
        S_STOP  = 10'h100,
        S_SHUT  = 10'h200
    } lsbc_state_e;
    // Kind of sequence on the bus, one-hot
    typedef enum logic [2:0] {
        K_LOCK = 3'h1,
        K_INTA = 3'h2,
        K_SPEC = 3'h4
    } lsbc_kind_e;
    // Core special cycle requests, one-hot
    localparam logic [2:0] SP_HALT  = 3'h1;
    localparam logic [2:0] SP_WBACK = 3'h2;
    localparam logic [2:0] SP_INVD  = 3'h4;
    // Cycle definition pins
    typedef struct packed {
        logic        dc;
        logic        mio;
        logic        wr;
        logic [7:0]  be;
        logic [31:3] addr;
    } lsbc_bus_s;
    // Byte enable encodings
    localparam logic [7:0] BE_INTA1 = 8'hef;
    localparam logic [7:0] BE_INTA2 = 8'hfe;
    localparam logic [7:0] BE_STPG  = 8'hfb;
    localparam logic [7:0] BE_FLACK = 8'hef;
    localparam logic [7:0] BE_WBACK = 8'hf7;
    localparam logic [7:0] BE_HALT  = 8'hfb;
    localparam logic [7:0] BE_FLUSH = 8'hfd;
    localparam logic [7:0] BE_SHUT  = 8'hfe;
    localparam logic [7:0] BE_ALL   = 8'h00;
    // Address bits 4:3 of special cycles
    localparam logic [1:0] A43_STPG = 2'h2;
    localparam logic [1:0] A43_NORM = 2'h0;
    // Fetch address after soft init
    localparam logic [31:0] RESET_VEC = 32'hffff_fff0;
    // Init lead before I/O write ready
    localparam logic [1:0] INIT_LEAD = 2'h3;
endpackage

// *** core/lsbc_top.sv ***
// Locked, interrupt acknowledge and special bus cycle sequencer
// Summary of operation
// (R1) Lock released one clock between locked sequences
// (R2) Lock with first strobe, released on last ready
// (R3) Flush touched lines first; locked reads uncached
// (R4) Misaligned locked transfer adds cycle, split asserted
// (R5) Backoff aborts cycle and floats all outputs
// (R6) Writeback during backoff keeps lock asserted
// (R7) Restart on edge backoff seen deasserted
// (R8) System keeps memory unchanged while backed off
// (R9) Interrupt: locked read pair, vector from second
// (R10) Acknowledge pins low, address zero, EF/FE
// (R11) Interrupt request held until acknowledge completes
// (R12) Special cycles: data/code 0, mem/io 0, write 1
// (R13) Special cycle byte enable and address encodings
// (R14) System answers every special cycle with ready
// (R15) Flush request: write back, invalidate, acknowledge
// (R16) Triple fault: shutdown cycle, then stay shut
// (R17) Shutdown left by NMI, init, reset, SMI
// (R18) Stop: pipe flush, drain, grant, then stop; code runs the grant cycle before waiting for write buffer empty
// (R19) Stop request held until stop grant completes
// (R20) Init acted at boundary; three-edge lead rule
// (R21) Init pulse width set by system logic
// (R22) Init: flush pipe, refetch reset vector, keep caches
`timescale 1ns/1ps
`default_nettype none
module lsbc_top
    import lsbc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic        CLK_EN,
    // Bus outputs
    output logic             ADDR_STROBE_N,
    output logic             BUS_LOCK_N,
    output logic             SPLIT_CYCLE,
    output logic             DATA_CODE_SEL,
    output logic             MEM_IO_SEL,
    output logic             WRITE_READ_SEL,
    output logic [31:3]      ADDR,
    output logic [7:0]       BYTE_ENABLES_N,
    output logic             BUS_OE,
    // Bus inputs
    input  wire logic        BURST_READY_N,
    input  wire logic        BACKOFF_N,
    input  wire logic [7:0]  DATA_IN,
    // System requests
    input  wire logic        MASKABLE_IRQ,
    input  wire logic        CLOCK_STOP_REQ_N,
    input  wire logic        EXT_WRITE_BUFFER_EMPTY_N,
    input  wire logic        CACHE_FLUSH_REQ_N,
    input  wire logic        SOFT_INIT,
    input  wire logic        NMI_REQ,
    input  wire logic        SYS_MGMT_IRQ_N,
    // Core side requests
    input  wire logic        INSTR_BOUNDARY,
    input  wire logic        BUS_IDLE,
    input  wire logic        LOCK_REQ,
    input  wire logic [31:3] LOCK_ADDR,
    input  wire logic [2:0]  LOCK_CYCLES,
    input  wire logic        LOCK_MISALIGN,
    input  wire logic        SPEC_REQ,
    input  wire logic [2:0]  SPEC_KIND,
    input  wire logic        TRIPLE_FAULT,
    input  wire logic        IO_WR_BURST_READY_N,
    // Cache handshakes
    output logic             CACHE_FLUSH,
    output logic             CACHE_ALL,
    input  wire logic        CACHE_DONE,
    output logic             NO_CACHE,
    input  wire logic        WB_HIT,
    output logic             WB_RUN,
    input  wire logic        WB_DONE,
    // Core side results
    output logic             BUSY,
    output logic [7:0]       IRQ_VECTOR,
    output logic             IRQ_VALID,
    output logic             PIPE_FLUSH,
    output logic             INIT_GO,
    output logic [31:0]      FETCH_ADDR,
    output logic             CLOCK_STOPPED,
    output logic             SHUTDOWN
);

    lsbc_state_e st;
    lsbc_state_e next_st;
    lsbc_kind_e  kind;
    lsbc_kind_e  next_kind;
    logic [2:0]  idx;
    logic [2:0]  next_idx;
    logic [2:0]  last;
    logic [2:0]  next_last;
    logic [7:0]  spc_be;
    logic [7:0]  next_spc_be;
    logic [1:0]  spc_a43;
    logic [1:0]  next_spc_a43;
    logic [31:3] lk_addr;
    logic        split;
    logic        next_split;
    logic        wb_need;
    logic        flush_pend;
    logic        init_pend;
    logic        init_defer;
    logic [1:0]  init_age;
    logic        post_shut;
    logic        next_post_shut;
    logic        cache_all;
    logic        next_cache_all;
    logic        go_init;
    logic        go_stop;

    // Assertion clock and reset
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    // Pin values of the current cycle
    function automatic lsbc_bus_s cyc_fn(input lsbc_kind_e k, input logic [2:0] i,
        input logic [31:3] a, input logic [7:0] be,
        input logic [1:0] a43);
        lsbc_bus_s b;
        b = '0;
        case (k)
            K_INTA: begin
                b.be = (i == 3'h0) ? BE_INTA1 : BE_INTA2; // R10
            end
            K_SPEC: begin
                b.wr = 1'b1; // R12
                b.be = be; // R13
                b.addr[4:3] = a43; // R13
            end
            default: begin
                b.dc   = 1'b1;
                b.mio  = 1'b1;
                b.wr   = (i != 3'h0);
                b.be   = BE_ALL;
                b.addr = a + {26'h0, i}; // R4
            end
        endcase
        return b;
    endfunction

    // Decoded state
    wire       in_cyc   = (st == S_ADDR) || (st == S_DATA);
    wire       locked   = (kind == K_LOCK) || (kind == K_INTA);
    wire       ready    = !BURST_READY_N && BACKOFF_N;
    wire       final_rd = (st == S_DATA) && ready && (idx == last);
    wire       stop_req = !CLOCK_STOP_REQ_N;
    wire       shut_out = NMI_REQ || SOFT_INIT || !SYS_MGMT_IRQ_N;
    wire [2:0] lk_last  = LOCK_CYCLES - 3'h1 + {2'h0, LOCK_MISALIGN};
    lsbc_bus_s bus;
    assign bus = cyc_fn(kind, idx, lk_addr, spc_be, spc_a43);

    // Bus pins; floated in backoff
    assign BUS_OE         = in_cyc || (st == S_WB); // R5
    assign ADDR_STROBE_N  = !(st == S_ADDR);
    assign BUS_LOCK_N     = !(locked && (in_cyc || (st == S_WB))); // R2 R6
    assign SPLIT_CYCLE    = split && in_cyc; // R4
    assign DATA_CODE_SEL  = bus.dc;
    assign MEM_IO_SEL     = bus.mio;
    assign WRITE_READ_SEL = bus.wr;
    assign ADDR           = bus.addr;
    assign BYTE_ENABLES_N = bus.be;
    assign CACHE_FLUSH    = (st == S_FLUSH); // R3 R15
    assign CACHE_ALL      = cache_all;
    assign NO_CACHE       = (kind == K_LOCK) && in_cyc; // R3
    assign WB_RUN         = (st == S_WB); // R6
    assign BUSY           = (st != S_IDLE);
    assign CLOCK_STOPPED  = (st == S_STOP); // R18
    assign SHUTDOWN       = (st == S_SHUT); // R16
    assign go_init = (st == S_IDLE) && INSTR_BOUNDARY && init_pend && !init_defer; // R20
    assign go_stop = (st == S_IDLE) && INSTR_BOUNDARY && !go_init && stop_req && BUS_IDLE; // R18

    // Next state and sequence setup
    always_comb begin
        next_st        = st;
        next_kind      = kind;
        next_idx       = idx;
        next_last      = last;
        next_spc_be    = spc_be;
        next_spc_a43   = spc_a43;
        next_split     = split;
        next_post_shut = post_shut;
        next_cache_all = cache_all;
        case (st)
            S_IDLE: begin
                next_idx       = 3'h0;
                next_last      = 3'h0;
                next_split     = 1'b0;
                next_post_shut = 1'b0;
                next_spc_a43   = A43_NORM;
                next_kind      = K_SPEC;
                if (TRIPLE_FAULT) begin
                    next_spc_be    = BE_SHUT; // R16
                    next_post_shut = 1'b1;
                    next_st        = S_ADDR;
                end else if (flush_pend) begin
                    next_spc_be    = BE_FLACK; // R15
                    next_cache_all = 1'b1;
                    next_st        = S_FLUSH;
                end else if (go_init) begin
                    next_st = S_IDLE; // R22
                end else if (go_stop) begin
                    next_spc_be  = BE_STPG;
                    next_spc_a43 = A43_STPG; // R13
                    next_st      = S_ADDR;
                end else if (INSTR_BOUNDARY && MASKABLE_IRQ) begin
                    next_kind = K_INTA; // R9
                    next_last = 3'h1;
                    next_st   = S_ADDR;
                end else if (INSTR_BOUNDARY && LOCK_REQ) begin
                    next_kind      = K_LOCK;
                    next_last      = lk_last; // R4
                    next_split     = LOCK_MISALIGN; // R4
                    next_cache_all = 1'b0;
                    next_st        = S_FLUSH; // R3
                end else if (INSTR_BOUNDARY && SPEC_REQ) begin
                    next_st = S_ADDR;
                    case (SPEC_KIND)
                        SP_WBACK: next_spc_be = BE_WBACK;
                        SP_INVD:  next_spc_be = BE_FLUSH;
                        default:  next_spc_be = BE_HALT;
                    endcase
                end
            end
            S_FLUSH: begin
                if (CACHE_DONE) begin
                    next_st = S_ADDR;
                end
            end
            S_ADDR: begin
                next_st = BACKOFF_N ? S_DATA : S_BACKOFF_N; // R5
            end
            S_DATA: begin
                if (!BACKOFF_N) begin
                    next_st = S_BACKOFF_N; // R5
                end else if (final_rd) begin
                    if (post_shut) begin
                        next_st = S_SHUT; // R16
                    end else if (spc_a43 == A43_STPG && kind == K_SPEC) begin
                        next_st = S_EXT_WRITE_BUFFER_EMPTY_N; // R18
                    end else begin
                        next_st = locked ? S_GAP : S_IDLE; // R1
                    end
                end else if (ready) begin
                    next_idx = idx + 3'h1;
                    next_st  = S_ADDR;
                end
            end
            S_BACKOFF_N: begin
                if (BACKOFF_N) begin
                    next_st = (wb_need || WB_HIT) ? S_WB : S_ADDR; // R6 R7
                end
            end
            S_WB: begin
                if (WB_DONE) begin
                    next_st = S_ADDR; // R6
                end
            end
            S_EXT_WRITE_BUFFER_EMPTY_N: begin
                if (!EXT_WRITE_BUFFER_EMPTY_N) begin
                    next_st = S_STOP; // R18
                end
            end
            S_STOP: begin
                if (!stop_req) begin
                    next_st = S_IDLE;
                end
            end
            S_SHUT: begin
                if (shut_out) begin
                    next_st = S_IDLE; // R17
                end
            end
            default: next_st = S_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            st        <= S_IDLE;
            kind      <= K_SPEC;
            idx       <= 3'h0;
            last      <= 3'h0;
            spc_be    <= BE_HALT;
            spc_a43   <= A43_NORM;
            split     <= 1'b0;
            post_shut <= 1'b0;
            cache_all <= 1'b0;
            lk_addr   <= '0;
        end else if (CLK_EN) begin
            st        <= next_st;
            kind      <= next_kind;
            idx       <= next_idx;
            last      <= next_last;
            spc_be    <= next_spc_be;
            spc_a43   <= next_spc_a43;
            split     <= next_split;
            post_shut <= next_post_shut;
            cache_all <= next_cache_all;
            if (st == S_IDLE && LOCK_REQ) begin
                lk_addr <= LOCK_ADDR;
            end
        end
    end

    // Sticky requests; set wins
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            flush_pend <= 1'b0;
            wb_need    <= 1'b0;
            init_pend  <= 1'b0;
            init_defer <= 1'b0;
            init_age   <= 2'h0;
        end else if (CLK_EN) begin
            if (!CACHE_FLUSH_REQ_N) begin
                flush_pend <= 1'b1; // R15
            end else if (st == S_FLUSH && cache_all && CACHE_DONE) begin
                flush_pend <= 1'b0;
            end
            if (st == S_BACKOFF_N && WB_HIT) begin
                wb_need <= 1'b1;
            end else if (st == S_WB && WB_DONE) begin
                wb_need <= 1'b0;
            end
            if (SOFT_INIT) begin
                init_pend <= 1'b1; // R20
            end else if (go_init) begin
                init_pend <= 1'b0;
            end
            if (!SOFT_INIT && !init_pend) begin
                init_age <= 2'h0;
            end else if (init_age != INIT_LEAD) begin
                init_age <= init_age + 2'h1;
            end
            if (IO_WR_BURST_READY_N && (init_pend || SOFT_INIT) && init_age < INIT_LEAD) begin
                init_defer <= 1'b1; // R20
            end else if (INSTR_BOUNDARY && st == S_IDLE) begin
                init_defer <= 1'b0;
            end
        end
    end

    // Results to the core
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            IRQ_VECTOR <= 8'h00;
            IRQ_VALID  <= 1'b0;
            PIPE_FLUSH <= 1'b0;
            INIT_GO    <= 1'b0;
            FETCH_ADDR <= RESET_VEC;
        end else if (CLK_EN) begin
            IRQ_VALID  <= (kind == K_INTA) && final_rd; // R9
            PIPE_FLUSH <= go_init || go_stop; // R18 R22
            INIT_GO    <= go_init; // R22
            if ((kind == K_INTA) && final_rd) begin
                IRQ_VECTOR <= DATA_IN; // R9
            end
            if (go_init) begin
                FETCH_ADDR <= RESET_VEC; // R22
            end
        end
    end

    // Checks on the sequencing
    property p_lock_first;
        (!ADDR_STROBE_N && locked && idx == 3'h0) |-> !BUS_LOCK_N;
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("lock late"); // R2

    property p_lock_end;
        (CLK_EN && final_rd && locked) |=> BUS_LOCK_N;
    endproperty
    a_lock_end: assert property (p_lock_end) else $error("lock held"); // R2

    property p_lock_gap;
        (CLK_EN && final_rd && locked) |=> (BUS_LOCK_N && ADDR_STROBE_N);
    endproperty
    a_lock_gap: assert property (p_lock_gap) else $error("no lock gap"); // R1

    property p_backoff_n_float;
        (CLK_EN && in_cyc && !BACKOFF_N) |=> !BUS_OE;
    endproperty
    a_backoff_n_float: assert property (p_backoff_n_float) else $error("not floated"); // R5

    sequence s_backoff_n_release;
        (CLK_EN && st == S_BACKOFF_N && BACKOFF_N && !wb_need && !WB_HIT);
    endsequence
    property p_restart;
        s_backoff_n_release |=> (!ADDR_STROBE_N && BUS_OE);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // R7

    property p_wb_lock;
        (WB_RUN && locked) |-> (!BUS_LOCK_N && BUS_OE);
    endproperty
    a_wb_lock: assert property (p_wb_lock) else $error("lock lost in wb"); // R6

    property p_inta_pins;
        (!ADDR_STROBE_N && kind == K_INTA) |-> (!DATA_CODE_SEL && !MEM_IO_SEL
            && !WRITE_READ_SEL && ADDR == '0
            && BYTE_ENABLES_N == ((idx == 3'h0) ? 8'hef : 8'hfe));
    endproperty
    a_inta_pins: assert property (p_inta_pins) else $error("bad inta"); // R10

    property p_vector;
        (CLK_EN && final_rd && kind == K_INTA) |=> (IRQ_VALID
            && IRQ_VECTOR == $past(DATA_IN));
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector"); // R9

    property p_spec_pins;
        (!ADDR_STROBE_N && kind == K_SPEC) |-> (!DATA_CODE_SEL && !MEM_IO_SEL
            && WRITE_READ_SEL && ADDR[31:5] == '0);
    endproperty
    a_spec_pins: assert property (p_spec_pins) else $error("bad special"); // R12

    property p_stop_ext_write_buffer_empty_n;
        $rose(CLOCK_STOPPED) |-> !$past(EXT_WRITE_BUFFER_EMPTY_N);
    endproperty
    a_stop_ext_write_buffer_empty_n: assert property (p_stop_ext_write_buffer_empty_n) else $error("early stop"); // R18

    property p_shut_stay;
        (SHUTDOWN && !shut_out) |=> SHUTDOWN;
    endproperty
    a_shut_stay: assert property (p_shut_stay) else $error("left shutdown"); // R16

endmodule
`default_nettype wire

// *** sim/lsbc_sys_model.sv ***
// System logic model answering the bus cycles
`timescale 1ns/1ps
`default_nettype none
module lsbc_sys_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bus from the sequencer
    input  wire logic       strobe_n,
    input  wire logic       oe,
    // Bench controls
    input  wire logic [3:0] waits,
    input  wire logic       hold,
    input  wire logic [7:0] vec,
    // Answers to the sequencer
    output logic            ready_n,
    output logic            backoff_n_n,
    output logic [7:0]      data
);
    logic       pend;
    logic       flip;
    logic [3:0] cnt;
    // Vector with ready, changing pattern otherwise
    assign data = ready_n ? ~vec ^ {8{flip}} : vec;
    // Ready after waits; backoff drops the cycle
    always_ff @(posedge clk) begin
        ready_n <= 1'b1;
        backoff_n_n  <= !hold;
        flip    <= !flip;
        if (!rstn) begin
            pend <= 1'b0;
            flip <= 1'b0;
        end else if (!backoff_n_n) begin
            pend <= 1'b0;
        end else if (!strobe_n && oe) begin
            pend <= 1'b1;
            cnt  <= waits;
        end else if (pend && cnt == 4'h0) begin
            ready_n <= 1'b0;
            pend    <= 1'b0;
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lsbc_pkg::*;
    // Drives and design outputs
    logic        SYS_CLK, RSTN, BACKOFF_N, BURST_READY_N, MASKABLE_IRQ, CLOCK_STOP_REQ_N;
    logic        EXT_WRITE_BUFFER_EMPTY_N, CACHE_FLUSH_REQ_N, SOFT_INIT, NMI_REQ, hold;
    logic        INSTR_BOUNDARY, LOCK_REQ, LOCK_MISALIGN, SPEC_REQ, TRIPLE_FAULT;
    logic        CACHE_DONE, WB_HIT, WB_DONE, ADDR_STROBE_N, BUS_LOCK_N, SPLIT_CYCLE;
    logic        DATA_CODE_SEL, MEM_IO_SEL, WRITE_READ_SEL, BUS_OE, CACHE_FLUSH, CACHE_ALL;
    logic        NO_CACHE, WB_RUN, BUSY, IRQ_VALID, PIPE_FLUSH, INIT_GO, CLOCK_STOPPED;
    logic        SHUTDOWN, lk, lkq, sp;
    logic [31:3] LOCK_ADDR, ADDR;
    logic [2:0]  LOCK_CYCLES, SPEC_KIND;
    logic [7:0]  DATA_IN, vec, BYTE_ENABLES_N, IRQ_VECTOR;
    logic [3:0]  waits;
    logic [31:0] FETCH_ADDR;
    lsbc_bus_s   cyc, prev;
    int          ncyc, nrise, nfl, nall, npf, nnc, miscompares, check_count, k;

    lsbc_top DUT (.SYS_CLK, .RSTN, .CLK_EN(1'b1), .ADDR_STROBE_N, .BUS_LOCK_N, .SPLIT_CYCLE,
        .DATA_CODE_SEL, .MEM_IO_SEL, .WRITE_READ_SEL, .ADDR, .BYTE_ENABLES_N, .BUS_OE,
        .BURST_READY_N, .BACKOFF_N, .DATA_IN, .MASKABLE_IRQ, .CLOCK_STOP_REQ_N,
        .EXT_WRITE_BUFFER_EMPTY_N, .CACHE_FLUSH_REQ_N, .SOFT_INIT, .NMI_REQ,
        .SYS_MGMT_IRQ_N(1'b1), .INSTR_BOUNDARY, .BUS_IDLE(1'b1), .LOCK_REQ, .LOCK_ADDR,
        .LOCK_CYCLES, .LOCK_MISALIGN, .SPEC_REQ, .SPEC_KIND, .TRIPLE_FAULT,
        .IO_WR_BURST_READY_N(1'b0), .CACHE_FLUSH, .CACHE_ALL, .CACHE_DONE, .NO_CACHE, .WB_HIT,
        .WB_RUN, .WB_DONE, .BUSY, .IRQ_VECTOR, .IRQ_VALID, .PIPE_FLUSH, .INIT_GO,
        .FETCH_ADDR, .CLOCK_STOPPED, .SHUTDOWN);

    lsbc_sys_model u_sys (.clk(SYS_CLK), .rstn(RSTN), .strobe_n(ADDR_STROBE_N),
        .oe(BUS_OE), .waits, .hold, .vec, .ready_n(BURST_READY_N), .backoff_n_n(BACKOFF_N),
        .data(DATA_IN));

    // Clock
    always #20 SYS_CLK = ~SYS_CLK;

    // Cache answers; record of each strobed cycle
    always @(posedge SYS_CLK) begin
        CACHE_DONE <= CACHE_FLUSH === 1'b1 && !CACHE_DONE;
        WB_DONE    <= WB_RUN === 1'b1 && !WB_DONE;
        lkq        <= BUS_LOCK_N;
        nrise      <= nrise + int'(BUS_LOCK_N === 1'b1 && lkq === 1'b0);
        nfl        <= nfl + int'(CACHE_FLUSH === 1'b1 && CACHE_ALL === 1'b0);
        nall       <= nall + int'(CACHE_FLUSH === 1'b1 && CACHE_ALL === 1'b1);
        npf        <= npf + int'(PIPE_FLUSH === 1'b1);
        if (ADDR_STROBE_N === 1'b0 && BUS_OE === 1'b1) begin
            prev <= cyc;
            cyc  <= {DATA_CODE_SEL, MEM_IO_SEL, WRITE_READ_SEL, BYTE_ENABLES_N, ADDR};
            lk   <= BUS_LOCK_N;
            sp   <= SPLIT_CYCLE;
            nnc  <= nnc + int'(NO_CACHE === 1'b1);
            ncyc <= ncyc + 1;
        end
    end

    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Boundary until busy, then drop requests
    task automatic take();
        INSTR_BOUNDARY <= 1'b1;
        k = 0;
        while (BUSY !== 1'b1 && k < 60) begin
            @(negedge SYS_CLK);
            k++;
        end
        @(posedge SYS_CLK);
        {INSTR_BOUNDARY, LOCK_REQ, SPEC_REQ, TRIPLE_FAULT, SOFT_INIT} <= 5'h00;
        CACHE_FLUSH_REQ_N <= 1'b1;
    endtask

    // Wait until the sequencer is idle again
    task automatic idle();
        k = 0;
        while (BUSY !== 1'b0 && k < 200) begin
            @(negedge SYS_CLK);
            k++;
        end
        @(posedge SYS_CLK);
    endtask

    // Halt, writeback and invalidate cycles
    task automatic t_spec();
        logic [2:0] kd [3] = '{SP_HALT, SP_WBACK, SP_INVD};
        logic [7:0] bv [3] = '{BE_HALT, BE_WBACK, BE_FLUSH};
        for (int i = 0; i < 3; i++) begin
            SPEC_KIND <= kd[i];
            SPEC_REQ  <= 1'b1;
            take();
            idle();
            chk(cyc, {3'h1, bv[i], 29'h0});
            chk(lk, 1'b1);
        end
        $display("spec done");
    endtask

    // Interrupt acknowledge pair with slow ready
    task automatic t_maskable_irq();
        vec          <= 8'h5a;
        waits        <= 4'h2;
        MASKABLE_IRQ <= 1'b1;
        take();
        idle();
        MASKABLE_IRQ <= 1'b0;
        waits        <= 4'h0;
        chk(prev, {3'h0, BE_INTA1, 29'h0});
        chk(cyc, {3'h0, BE_INTA2, 29'h0});
        chk(lk, 1'b0);
        chk(IRQ_VECTOR, 8'h5a);
        $display("maskable_irq done");
    endtask

    // Misaligned then aligned locked operation
    task automatic t_lock();
        int n0, r0, f0, c0;
        n0 = ncyc;
        r0 = nrise;
        f0 = nfl;
        c0 = nnc;
        LOCK_ADDR     <= 29'h100;
        LOCK_CYCLES   <= 3'h2;
        LOCK_MISALIGN <= 1'b1;
        LOCK_REQ      <= 1'b1;
        take();
        idle();
        chk(ncyc - n0, 3);
        chk(sp, 1'b1);
        chk(cyc.addr, 29'h102);
        chk(lk, 1'b0);
        chk(nfl > f0, 1'b1);
        chk(nnc - c0, 3);
        LOCK_MISALIGN <= 1'b0;
        LOCK_REQ      <= 1'b1;
        take();
        idle();
        chk(ncyc - n0, 5);
        chk(nrise - r0, 2);
        $display("lock done");
    endtask

    // Backoff in locked write, writeback, restart
    task automatic t_backoff_n();
        int n0;
        n0 = ncyc;
        waits    <= 4'h3;
        LOCK_REQ <= 1'b1;
        take();
        k = 0;
        while (ncyc < n0 + 2 && k < 60) begin
            @(negedge SYS_CLK);
            k++;
        end
        @(posedge SYS_CLK);
        hold <= 1'b1;
        repeat (3) @(negedge SYS_CLK);
        chk(BUS_OE, 1'b0);
        @(posedge SYS_CLK);
        WB_HIT <= 1'b1;
        @(posedge SYS_CLK);
        hold <= 1'b0;
        k = 0;
        while (WB_RUN !== 1'b1 && k < 20) begin
            @(negedge SYS_CLK);
            k++;
        end
        chk(BUS_LOCK_N, 1'b0);
        chk(BUS_OE, 1'b1);
        idle();
        WB_HIT <= 1'b0;
        waits  <= 4'h0;
        chk(ncyc - n0, 3);
        chk(cyc.wr, 1'b1);
        $display("backoff done");
    endtask

    // Flush request, then acknowledge cycle
    task automatic t_flush();
        int a0;
        a0 = nall;
        CACHE_FLUSH_REQ_N <= 1'b0;
        take();
        idle();
        chk(nall > a0, 1'b1);
        chk(cyc, {3'h1, BE_FLACK, 29'h0});
        $display("flush done");
    endtask

    // Stop grant; clock stops once buffers empty
    task automatic t_stop();
        int n0, p0;
        n0 = ncyc;
        p0 = npf;
        CLOCK_STOP_REQ_N <= 1'b0;
        take();
        k = 0;
        while (ncyc == n0 && k < 60) begin
            @(negedge SYS_CLK);
            k++;
        end
        repeat (4) @(negedge SYS_CLK);
        chk(cyc, {3'h1, BE_STPG, 27'h0, A43_STPG});
        chk(npf > p0, 1'b1);
        chk(CLOCK_STOPPED, 1'b0);
        @(posedge SYS_CLK);
        EXT_WRITE_BUFFER_EMPTY_N <= 1'b0;
        repeat (4) @(negedge SYS_CLK);
        chk(CLOCK_STOPPED, 1'b1);
        @(posedge SYS_CLK);
        CLOCK_STOP_REQ_N         <= 1'b1;
        EXT_WRITE_BUFFER_EMPTY_N <= 1'b1;
        idle();
        $display("stop done");
    endtask

    // Soft init pulse, acted at a boundary
    task automatic t_init();
        SOFT_INIT <= 1'b1;
        @(posedge SYS_CLK);
        SOFT_INIT <= 1'b0;
        repeat (3) @(negedge SYS_CLK);
        chk(INIT_GO, 1'b0);
        @(posedge SYS_CLK);
        INSTR_BOUNDARY <= 1'b1;
        k = 0;
        while (INIT_GO !== 1'b1 && k < 20) begin
            @(negedge SYS_CLK);
            k++;
        end
        chk(INIT_GO, 1'b1);
        chk(PIPE_FLUSH, 1'b1);
        chk(FETCH_ADDR, RESET_VEC);
        @(posedge SYS_CLK);
        INSTR_BOUNDARY <= 1'b0;
        idle();
        $display("init done");
    endtask

    // Triple fault shutdown, left on NMI
    task automatic t_shut();
        int n0;
        n0 = ncyc;
        TRIPLE_FAULT <= 1'b1;
        take();
        repeat (10) @(negedge SYS_CLK);
        chk(cyc, {3'h1, BE_SHUT, 29'h0});
        chk(ncyc - n0, 1);
        chk(SHUTDOWN, 1'b1);
        @(posedge SYS_CLK);
        NMI_REQ <= 1'b1;
        idle();
        NMI_REQ <= 1'b0;
        chk(SHUTDOWN, 1'b0);
        $display("shut done");
    endtask

    // Counts, verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (8000) @(posedge SYS_CLK);
        miscompares++;
        end_sim();
    end

    // Reset, then the scenarios in turn
    initial begin
        SYS_CLK = 1'b0;
        RSTN = 1'b0;
        {MASKABLE_IRQ, SOFT_INIT, NMI_REQ, hold, INSTR_BOUNDARY, LOCK_REQ} = 6'h00;
        {LOCK_MISALIGN, SPEC_REQ, TRIPLE_FAULT, CACHE_DONE, WB_HIT, WB_DONE} = 6'h00;
        {CLOCK_STOP_REQ_N, EXT_WRITE_BUFFER_EMPTY_N, CACHE_FLUSH_REQ_N} = 3'h7;
        LOCK_ADDR = 29'h0;
        LOCK_CYCLES = 3'h2;
        SPEC_KIND = SP_HALT;
        vec = 8'h00;
        waits = 4'h0;
        repeat (5) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        t_spec();
        t_maskable_irq();
        t_lock();
        t_backoff_n();
        t_flush();
        t_stop();
        t_init();
        t_shut();
        end_sim();
    end
endmodule
`default_nettype wire
